// [fbn_pkg.sv]
/*
 * Shared constants of the fieldbus slave node configuration block: setting codes,
 * reset values, rate divisors and watchdog timing.
 * Assumes a 100 MHz system clock and settings presented as plain ports.
 */
// Summary of operation
// - The node acts only as a slave under one master, on a segment of at most 63 slaves.
// - Each node address on the segment is unique, so the master must not use ours.
// - Rate code 00, 01 and 02 give 125, 250 and 500 kbps, and 00 holds after reset.
// - Master and node must run at the same bit rate to talk at all.
// - The node address accepts 0 to 63 and defaults to 63.
// - Network control is off with code 00 and on with code 01, default 01.
// - The watchdog timeout is 0.00 to 99.99 s in 0.01 s steps, default 1.00 s.
// - A comm error applies action 00 trip to 04 decelerate-and-stop, default 01.
// - Master idle applies its own action from the same five codes, default 01.
// - Consumed-data instance is 20, 21 or 100, default 100.
// - Produced-data instance is 70, 71 or 101, default 101.
// - Pole setting 00 means Hz commands, even 02 to 38 means RPM commands.
// - A poll carries four 16-bit words each way and the reply is the acknowledgement.
package fbn_pkg;
	localparam logic [1:0] RATE_125K  = 2'h0;
	localparam logic [1:0] RATE_250K  = 2'h1;
	localparam logic [1:0] RATE_500K  = 2'h2;
	localparam logic [1:0] RATE_RESET = RATE_125K;
	// System clock cycles per network bit for each rate.
	localparam int CLK_HZ            = 100_000_000;
	localparam logic [9:0] BIT_125K  = 10'(CLK_HZ / 125_000);
	localparam logic [9:0] BIT_250K  = 10'(CLK_HZ / 250_000);
	localparam logic [9:0] BIT_500K  = 10'(CLK_HZ / 500_000);
	localparam logic [5:0] ADDR_MAX   = 6'h3F;
	localparam logic [5:0] ADDR_RESET = 6'h3F;
	localparam logic [6:0] MAX_SLAVES = 7'h3F;
	localparam logic [1:0] CTRL_OFF   = 2'h0;
	localparam logic [1:0] CTRL_ON    = 2'h1;
	localparam logic [1:0] CTRL_RESET = CTRL_ON;
	// Watchdog in hundredths of a second.
	localparam logic [13:0] WD_MAX     = 14'h270F;
	localparam logic [13:0] WD_RESET   = 14'h0064;
	localparam int WD_TICK_NS          = 10_000_000;
	localparam int CLK_NS              = 10;
	localparam int WD_TICK_CYCLES      = WD_TICK_NS / CLK_NS;
	localparam logic [2:0] ACT_TRIP       = 3'h0;
	localparam logic [2:0] ACT_DEC_TRIP   = 3'h1;
	localparam logic [2:0] ACT_HOLD       = 3'h2;
	localparam logic [2:0] ACT_COAST      = 3'h3;
	localparam logic [2:0] ACT_DEC_STOP   = 3'h4;
	localparam logic [2:0] ACT_RESET      = ACT_DEC_TRIP;
	localparam logic [7:0] OUT_INST_A     = 8'h14;
	localparam logic [7:0] OUT_INST_B     = 8'h15;
	localparam logic [7:0] OUT_INST_C     = 8'h64;
	localparam logic [7:0] IN_INST_A      = 8'h46;
	localparam logic [7:0] IN_INST_B      = 8'h47;
	localparam logic [7:0] IN_INST_C      = 8'h65;
	localparam logic [5:0] POLES_MAX      = 6'h26;
	localparam logic [5:0] POLES_RESET    = 6'h00;
	localparam int POLL_WORDS             = 4;
	localparam int WORD_BITS              = 16;
	// Node supervision states.
	typedef enum logic [2:0] {
		FBN_OFF   = 3'b001,
		FBN_RUN   = 3'b010,
		FBN_FAULT = 3'b100
	} fbn_state_e;
endpackage

// [fbn_wdog.sv]
/*
 * Communication watchdog: counts 10 ms ticks since the last restart and flags expiry.
 * Assumes restart is a one-cycle pulse and timeout is held steady in hundredths of a second.
 */
`timescale 1ns/1ps
module fbn_wdog #(
	parameter int TICK_CYCLES = fbn_pkg::WD_TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        arm,
	input  wire logic        restart,
	input  wire logic [13:0] timeout,
	output logic             expired
);
	logic [23:0] tick_reg;
	logic [13:0] hund_reg;
	logic        tick;

	assign tick = (tick_reg == 24'(TICK_CYCLES - 1));

	// Prescaler for the 0.01 s step, restarted with the watchdog.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_reg <= 24'h000000;
		end else if (restart || !arm || tick) begin
			tick_reg <= 24'h000000;
		end else begin
			tick_reg <= tick_reg + 24'h000001;
		end
	end

	// Hundredths elapsed since the last poll; saturates at the limit.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hund_reg <= 14'h0000;
		end else if (restart || !arm) begin
			hund_reg <= 14'h0000;
		end else if (tick && hund_reg != 14'h3FFF) begin
			hund_reg <= hund_reg + 14'h0001;
		end
	end

	// Zero timeout disables expiry; expiry holds until restart or disarm.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			expired <= 1'b0;
		end else if (restart || !arm) begin
			expired <= 1'b0;
		end else if (timeout != 14'h0000 && hund_reg >= timeout) begin
			expired <= 1'b1;
		end
	end
endmodule

// [fbn_node.sv]
/*
 * Slave node configuration and supervision: validates settings, picks bit timing,
 * runs the watchdog and chooses the drive action on comm error or master idle.
 * Assumes the protocol engine presents a received poll as a one-cycle strobe with
 * four consumed words, and all setting inputs synchronous to CLK_SYS.
 */
`timescale 1ns/1ps
module fbn_node #(
	parameter int WD_TICK_CYCLES = fbn_pkg::WD_TICK_CYCLES
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic        CFG_LOAD,
	input  wire logic [1:0]  CFG_RATE,
	input  wire logic [5:0]  CFG_ADDR,
	input  wire logic [1:0]  CFG_CTRL_EN,
	input  wire logic [13:0] CFG_WD_TIMEOUT,
	input  wire logic [2:0]  CFG_ERR_ACT,
	input  wire logic [2:0]  CFG_IDLE_ACT,
	input  wire logic [7:0]  CFG_OUT_INST,
	input  wire logic [7:0]  CFG_IN_INST,
	input  wire logic [5:0]  CFG_POLES,
	input  wire logic [5:0]  MASTER_ADDR,
	input  wire logic        POLL_VALID,
	input  wire logic [5:0]  POLL_DEST,
	input  wire logic [63:0] POLL_DATA,
	input  wire logic        MASTER_IDLE,
	input  wire logic [63:0] PROD_DATA,
	input  wire logic        FAULT_CLEAR,
	output logic             CFG_REJECT,
	output logic [1:0]       RATE_CODE,
	output logic [9:0]       BIT_CYCLES,
	output logic [5:0]       NODE_ADDR,
	output logic             NET_CTRL_EN,
	output logic [13:0]      WD_TIMEOUT,
	output logic [7:0]       OUT_INST,
	output logic [7:0]       IN_INST,
	output logic [5:0]       POLES,
	output logic             SPEED_RPM,
	output logic             ADDR_CLASH,
	output logic [63:0]      CMD_DATA,
	output logic             CMD_VALID,
	output logic             RESP_VALID,
	output logic [63:0]      RESP_DATA,
	output logic             COMM_ERR,
	output logic             ACT_VALID,
	output logic [2:0]       ACT_CODE
);
	logic [2:0]        err_act_reg;
	logic [2:0]        idle_act_reg;
	logic              cfg_ok;
	logic              poll_ok;
	logic              wd_expired;

	fbn_pkg::fbn_state_e state_reg;
	fbn_pkg::fbn_state_e state_next;

	// Checks that an action code is one of the five defined.
	function automatic logic act_legal(input logic [2:0] a);
		act_legal = (a <= fbn_pkg::ACT_DEC_STOP);
	endfunction

	// Checks that a pole count is zero or even and within range.
	function automatic logic poles_legal(input logic [5:0] p);
		poles_legal = (p <= fbn_pkg::POLES_MAX) && !p[0];
	endfunction

	// Whole-set validation; an illegal field rejects the entire load.
	always_comb begin
		cfg_ok = (CFG_RATE <= fbn_pkg::RATE_500K)
			&& (CFG_ADDR <= fbn_pkg::ADDR_MAX)
			&& (CFG_CTRL_EN <= fbn_pkg::CTRL_ON)
			&& (CFG_WD_TIMEOUT <= fbn_pkg::WD_MAX)
			&& act_legal(CFG_ERR_ACT) && act_legal(CFG_IDLE_ACT)
			&& (CFG_OUT_INST == fbn_pkg::OUT_INST_A || CFG_OUT_INST == fbn_pkg::OUT_INST_B
				|| CFG_OUT_INST == fbn_pkg::OUT_INST_C)
			&& (CFG_IN_INST == fbn_pkg::IN_INST_A || CFG_IN_INST == fbn_pkg::IN_INST_B
				|| CFG_IN_INST == fbn_pkg::IN_INST_C)
			&& poles_legal(CFG_POLES);
	end

	// Settings register bank, loaded only when every field is legal.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			RATE_CODE    <= fbn_pkg::RATE_RESET;
			NODE_ADDR    <= fbn_pkg::ADDR_RESET;
			NET_CTRL_EN  <= (fbn_pkg::CTRL_RESET == fbn_pkg::CTRL_ON);
			WD_TIMEOUT   <= fbn_pkg::WD_RESET;
			err_act_reg  <= fbn_pkg::ACT_RESET;
			idle_act_reg <= fbn_pkg::ACT_RESET;
			OUT_INST     <= fbn_pkg::OUT_INST_C;
			IN_INST      <= fbn_pkg::IN_INST_C;
			POLES        <= fbn_pkg::POLES_RESET;
		end else if (CFG_LOAD && cfg_ok) begin
			RATE_CODE    <= CFG_RATE;
			NODE_ADDR    <= CFG_ADDR;
			NET_CTRL_EN  <= (CFG_CTRL_EN == fbn_pkg::CTRL_ON);
			WD_TIMEOUT   <= CFG_WD_TIMEOUT;
			err_act_reg  <= CFG_ERR_ACT;
			idle_act_reg <= CFG_IDLE_ACT;
			OUT_INST     <= CFG_OUT_INST;
			IN_INST      <= CFG_IN_INST;
			POLES        <= CFG_POLES;
		end
	end

	// Reject flag pulses for one cycle on an illegal load.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CFG_REJECT <= 1'b0;
		end else begin
			CFG_REJECT <= CFG_LOAD && !cfg_ok;
		end
	end

	// Bit time for the selected rate; the master must be set alike.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			BIT_CYCLES <= fbn_pkg::BIT_125K;
		end else begin
			unique case (RATE_CODE)
				fbn_pkg::RATE_250K: BIT_CYCLES <= fbn_pkg::BIT_250K;
				fbn_pkg::RATE_500K: BIT_CYCLES <= fbn_pkg::BIT_500K;
				default:            BIT_CYCLES <= fbn_pkg::BIT_125K;
			endcase
		end
	end

	// Speed units and address clash with the master.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			SPEED_RPM  <= 1'b0;
			ADDR_CLASH <= 1'b0;
		end else begin
			SPEED_RPM  <= (POLES != 6'h00);
			ADDR_CLASH <= (MASTER_ADDR == NODE_ADDR);
		end
	end

	// A poll counts only when addressed to us and the addresses differ.
	assign poll_ok = POLL_VALID && (POLL_DEST == NODE_ADDR) && !ADDR_CLASH;

	// Poll exchange: capture four command words and answer with four status words.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CMD_DATA   <= 64'h0000000000000000;
			CMD_VALID  <= 1'b0;
			RESP_DATA  <= 64'h0000000000000000;
			RESP_VALID <= 1'b0;
		end else begin
			CMD_VALID  <= poll_ok && NET_CTRL_EN && (state_reg == fbn_pkg::FBN_RUN);
			RESP_VALID <= poll_ok;
			if (poll_ok) begin
				CMD_DATA  <= POLL_DATA;
				RESP_DATA <= PROD_DATA;
			end
		end
	end

	// Watchdog, armed while network control is enabled.
	fbn_wdog #(
		.TICK_CYCLES (WD_TICK_CYCLES)
	) fbn_wdog_inst (
		.clk     (CLK_SYS),
		.rst_n   (RST_N),
		.arm     (NET_CTRL_EN),
		.restart (poll_ok),
		.timeout (WD_TIMEOUT),
		.expired (wd_expired)
	);

	// Supervision: a fault holds until cleared or control is turned off; a clear loses while the watchdog expiry still stands.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			fbn_pkg::FBN_OFF: begin
				if (NET_CTRL_EN) begin
					state_next = fbn_pkg::FBN_RUN;
				end
			end
			fbn_pkg::FBN_RUN: begin
				if (!NET_CTRL_EN) begin
					state_next = fbn_pkg::FBN_OFF;
				end else if (wd_expired) begin
					state_next = fbn_pkg::FBN_FAULT;
				end
			end
			fbn_pkg::FBN_FAULT: begin
				if (!NET_CTRL_EN) begin
					state_next = fbn_pkg::FBN_OFF;
				end else if (FAULT_CLEAR && !wd_expired) begin
					state_next = fbn_pkg::FBN_RUN;
				end
			end
			default: state_next = fbn_pkg::FBN_OFF;
		endcase
	end

	// State register.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= fbn_pkg::FBN_OFF;
		end else begin
			state_reg <= state_next;
		end
	end

	// Action output: comm error takes precedence over master idle.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			COMM_ERR  <= 1'b0;
			ACT_VALID <= 1'b0;
			ACT_CODE  <= fbn_pkg::ACT_RESET;
		end else begin
			COMM_ERR <= (state_next == fbn_pkg::FBN_FAULT);
			if (state_next == fbn_pkg::FBN_FAULT) begin
				ACT_VALID <= 1'b1;
				ACT_CODE  <= err_act_reg;
			end else if (state_next == fbn_pkg::FBN_RUN && MASTER_IDLE) begin
				ACT_VALID <= 1'b1;
				ACT_CODE  <= idle_act_reg;
			end else begin
				ACT_VALID <= 1'b0;
			end
		end
	end
endmodule

// [fbn_node_monitor.sv]
/* Port checker for the slave node block.
   Bound into every fbn_node; fbn_pkg is compiled first. */
`timescale 1ns/1ps
module fbn_node_monitor #(
	parameter int WD_TICK_CYCLES = fbn_pkg::WD_TICK_CYCLES
) (
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic        CFG_LOAD,
	input wire logic [1:0]  CFG_RATE,
	input wire logic [7:0]  CFG_OUT_INST,
	input wire logic [5:0]  CFG_POLES,
	input wire logic [5:0]  MASTER_ADDR,
	input wire logic        POLL_VALID,
	input wire logic [5:0]  POLL_DEST,
	input wire logic [63:0] PROD_DATA,
	input wire logic        CFG_REJECT,
	input wire logic [1:0]  RATE_CODE,
	input wire logic [9:0]  BIT_CYCLES,
	input wire logic [5:0]  NODE_ADDR,
	input wire logic        NET_CTRL_EN,
	input wire logic [13:0] WD_TIMEOUT,
	input wire logic [7:0]  OUT_INST,
	input wire logic [5:0]  POLES,
	input wire logic        SPEED_RPM,
	input wire logic        ADDR_CLASH,
	input wire logic        CMD_VALID,
	input wire logic        RESP_VALID,
	input wire logic [63:0] RESP_DATA,
	input wire logic        COMM_ERR,
	input wire logic        ACT_VALID
);
	int        quiet;
	wire logic take = POLL_VALID && POLL_DEST == NODE_ADDR && !ADDR_CLASH;
	wire logic bad  = CFG_RATE > 2'h2 || CFG_POLES > 6'h26 || CFG_POLES[0]
		|| !(CFG_OUT_INST inside {8'h14, 8'h15, 8'h64});
	// Counts cycles since the watchdog was last restarted or disarmed.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N)
			quiet <= 0;
		else if (take || !NET_CTRL_EN)
			quiet <= 0;
		else
			quiet <= quiet + 1;
	end
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	sequence take_s; take; endsequence
	sequence good_s; CFG_LOAD ##1 !CFG_REJECT; endsequence
	poll_reply_a:
	assert property (take_s |=> RESP_VALID && RESP_DATA == $past(PROD_DATA))
		else $error("taken poll got no reply");
	reply_cause_a:
	assert property (RESP_VALID |-> $past(POLL_VALID) && !$past(ADDR_CLASH))
		else $error("reply without a poll");
	cmd_enable_a:
	assert property (CMD_VALID |-> RESP_VALID && $past(NET_CTRL_EN))
		else $error("command while control off");
	bad_load_a:
	assert property (CFG_LOAD && bad |=> CFG_REJECT && $stable(RATE_CODE) && $stable(OUT_INST))
		else $error("illegal setting accepted");
	good_load_a:
	assert property (good_s |-> RATE_CODE == $past(CFG_RATE) && OUT_INST == $past(CFG_OUT_INST))
		else $error("legal setting not applied");
	bit_time_a:
	assert property ($stable(RATE_CODE) |-> BIT_CYCLES == (RATE_CODE == 2'h2 ? 10'h0C8
		: RATE_CODE == 2'h1 ? 10'h190 : 10'h320)) else $error("bit time wrong");
	rpm_mode_a:
	assert property ($stable(POLES) |-> SPEED_RPM == (POLES != 6'h00))
		else $error("speed unit wrong");
	addr_clash_a:
	assert property ($past(RST_N) && $stable(NODE_ADDR) && $stable(MASTER_ADDR)
		|-> ADDR_CLASH == (NODE_ADDR == MASTER_ADDR)) else $error("clash flag wrong");
	wd_expiry_a:
	assert property ($rose(COMM_ERR) |-> WD_TIMEOUT != 14'h0000
		&& quiet >= (WD_TIMEOUT - 1) * WD_TICK_CYCLES) else $error("early expiry");
	err_action_a:
	assert property (COMM_ERR [*3] |-> ACT_VALID) else $error("no error action");
endmodule

bind fbn_node fbn_node_monitor #(.WD_TICK_CYCLES(WD_TICK_CYCLES)) fbn_node_monitor_inst (.*);

// [fbn_master_model.sv]
/* Behavioural network master that sends one poll per go pulse.
   Shares the node clock, so both ends keep the same bit timing. */
`timescale 1ns/1ps
module fbn_master_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        go,
	input  wire logic [5:0]  dest,
	input  wire logic [63:0] data,
	output logic             poll_valid,
	output logic [5:0]       poll_dest,
	output logic [63:0]      poll_data
);
	// The single master sends four words per poll and scrambles lines between polls.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			poll_valid <= 1'h0;
			poll_dest  <= 6'h00;
			poll_data  <= 64'h0;
		end else begin
			poll_valid <= go;
			poll_dest  <= go ? dest : ~poll_dest;
			poll_data  <= go ? data : ~poll_data;
		end
	end
endmodule

// [fbn_node_bench.sv]
/* Self-checking bench for the slave node block.
   Needs fbn_pkg, the design, its checker and the master model. */
`timescale 1ns/1ps
module fbn_node_bench;
	logic        CLK_SYS, RST_N, CFG_LOAD, MASTER_IDLE, FAULT_CLEAR, POLL_VALID;
	logic        CFG_REJECT, NET_CTRL_EN, SPEED_RPM, ADDR_CLASH, CMD_VALID;
	logic        RESP_VALID, COMM_ERR, ACT_VALID, m_go, rej, got_r, got_c;
	logic [1:0]  CFG_RATE, CFG_CTRL_EN, RATE_CODE;
	logic [2:0]  CFG_ERR_ACT, CFG_IDLE_ACT, ACT_CODE;
	logic [5:0]  CFG_ADDR, CFG_POLES, MASTER_ADDR, POLL_DEST, NODE_ADDR, POLES, m_dest;
	logic [7:0]  CFG_OUT_INST, CFG_IN_INST, OUT_INST, IN_INST;
	logic [9:0]  BIT_CYCLES;
	logic [13:0] CFG_WD_TIMEOUT, WD_TIMEOUT;
	logic [63:0] POLL_DATA, PROD_DATA, CMD_DATA, RESP_DATA, m_data;
	int          n_errors, compares, i, n;
	fbn_node #(.WD_TICK_CYCLES(10)) fbn_node_inst (.*);
	fbn_master_model fbn_master_model_inst (.clk(CLK_SYS), .rst_n(RST_N), .go(m_go),
		.dest(m_dest), .data(m_data), .poll_valid(POLL_VALID), .poll_dest(POLL_DEST),
		.poll_data(POLL_DATA));
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Loads the whole setting set and keeps the reject flag.
	task automatic ld;
		@(posedge CLK_SYS);
		CFG_LOAD <= 1'h1;
		@(posedge CLK_SYS);
		CFG_LOAD <= 1'h0;
		@(negedge CLK_SYS);
		rej = CFG_REJECT;
		repeat (2) @(negedge CLK_SYS);
	endtask
	// Has the master poll one address and notes any reply or command.
	task automatic poll(input logic [5:0] d);
		@(posedge CLK_SYS);
		m_go      <= 1'h1;
		m_dest    <= d;
		m_data    <= {16'hA001, 16'hB002, 16'hC003, 10'h000, d};
		PROD_DATA <= {16'h1234, 16'h5678, 16'h9ABC, 10'h155, d};
		@(posedge CLK_SYS);
		m_go  <= 1'h0;
		got_r = 1'h0;
		got_c = 1'h0;
		repeat (4) begin
			@(negedge CLK_SYS);
			got_r = got_r | RESP_VALID;
			got_c = got_c | CMD_VALID;
		end
	endtask
	// Checks the settings that hold after reset.
	task automatic t_reset;
		@(negedge CLK_SYS);
		chk("rate", {RATE_CODE, BIT_CYCLES}, {2'h0, 10'h320});
		chk("addr", NODE_ADDR, 6'h3F);
		chk("ctrl", NET_CTRL_EN, 1'h1);
		chk("wd", WD_TIMEOUT, 14'h0064);
		chk("inst", {OUT_INST, IN_INST}, {8'h64, 8'h65});
		chk("rpm", SPEED_RPM, 1'h0);
		chk("flags", {CFG_REJECT, COMM_ERR, ACT_VALID}, 3'h0);
	endtask
	// Steps through every rate and instance, then three illegal loads.
	task automatic t_cfg;
		logic [7:0] oi [3] = '{8'h14, 8'h15, 8'h64};
		logic [7:0] ii [3] = '{8'h46, 8'h47, 8'h65};
		for (i = 0; i < 3; i++) begin
			@(posedge CLK_SYS);
			CFG_RATE     <= 2'(i);
			CFG_POLES    <= (i == 1) ? 6'h26 : 6'h00;
			CFG_OUT_INST <= oi[i];
			CFG_IN_INST  <= ii[i];
			ld;
			chk("rate", {rej, RATE_CODE, BIT_CYCLES}, {1'h0, 2'(i), 10'h320 >> i});
			chk("inst", {OUT_INST, IN_INST}, {oi[i], ii[i]});
			chk("rpm", SPEED_RPM, i == 1);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge CLK_SYS);
			CFG_RATE     <= (i == 0) ? 2'h3 : 2'h2;
			CFG_POLES    <= (i == 1) ? 6'h03 : 6'h04;
			CFG_OUT_INST <= (i == 2) ? 8'h16 : 8'h64;
			ld;
			chk("keep", {rej, RATE_CODE, POLES, OUT_INST}, {1'h1, 2'h2, 6'h00, 8'h64});
		end
	endtask
	// Polls our address, another address, then with a clashing master.
	task automatic t_poll;
		@(posedge CLK_SYS);
		CFG_ADDR     <= 6'h05;
		CFG_OUT_INST <= 8'h64;
		ld;
		chk("addr", NODE_ADDR, 6'h05);
		poll(6'h05);
		chk("data", {got_r, got_c, CMD_DATA}, {1'h1, 1'h1, m_data});
		chk("prod", RESP_DATA, PROD_DATA);
		poll(6'h06);
		chk("other", got_r, 1'h0);
		@(posedge CLK_SYS);
		MASTER_ADDR <= 6'h05;
		repeat (3) @(negedge CLK_SYS);
		chk("clash", ADDR_CLASH, 1'h1);
		poll(6'h05);
		chk("blocked", got_r, 1'h0);
		@(posedge CLK_SYS);
		MASTER_ADDR <= 6'h00;
	endtask
	// Turns network control off, tries an illegal code, turns it on again.
	task automatic t_ctrl;
		for (i = 0; i < 3; i++) begin
			@(posedge CLK_SYS);
			CFG_CTRL_EN <= (i == 1) ? 2'h2 : 2'(i >> 1);
			ld;
			poll(6'h05);
			chk("ctrl", {rej, NET_CTRL_EN, got_r, got_c}, {i == 1, 1'h1 & (i > 1),
				1'h1, 1'h1 & (i > 1)});
		end
	endtask
	// Applies every idle action code, then an illegal one.
	task automatic t_idle;
		for (i = 0; i < 6; i++) begin
			@(posedge CLK_SYS);
			CFG_WD_TIMEOUT <= 14'h0000;
			CFG_IDLE_ACT   <= 3'(i);
			ld;
			@(posedge CLK_SYS);
			MASTER_IDLE <= 1'h1;
			repeat (2) @(negedge CLK_SYS);
			// A refused code must leave the last legal idle action in force.
			chk("idle", {rej, ACT_VALID, ACT_CODE},
				{i == 5, 1'h1, 3'(i == 5 ? 4 : i)});
			@(posedge CLK_SYS);
			MASTER_IDLE <= 1'h0;
		end
	endtask
	// Lets the watchdog run out under every error action.
	task automatic t_wd;
		for (i = 0; i < 5; i++) begin
			@(posedge CLK_SYS);
			CFG_WD_TIMEOUT <= 14'h0005;
			CFG_ERR_ACT    <= 3'(i);
			CFG_IDLE_ACT   <= 3'h1;
			poll(6'h05);
			ld;
			for (n = 0; n < 100 && COMM_ERR !== 1'h1; n++)
				@(negedge CLK_SYS);
			if (n == 100) begin
				n_errors++;
				return;
			end
			// The first look is 6.5 cycles after the take; five 10-cycle steps must pass first.
			chk("late", n >= 44 && n <= 48, 1'h1);
			chk("act", {ACT_VALID, ACT_CODE}, {1'h1, 3'(i)});
			poll(6'h05);
			chk("fault poll", {got_r, got_c}, {1'h1, 1'h0});
			@(posedge CLK_SYS);
			FAULT_CLEAR <= 1'h1;
			@(posedge CLK_SYS);
			FAULT_CLEAR <= 1'h0;
			repeat (2) @(negedge CLK_SYS);
			chk("clear", COMM_ERR, 1'h0);
		end
	endtask
	// Free-running 100 MHz clock.
	initial begin
		CLK_SYS = 1'h0;
		forever #5 CLK_SYS = ~CLK_SYS;
	end
	// Resets the node, then runs every scenario.
	initial begin
		{RST_N, CFG_LOAD, MASTER_IDLE, FAULT_CLEAR, m_go, CFG_RATE, CFG_POLES} = '0;
		{n_errors, compares, MASTER_ADDR, m_dest, m_data, PROD_DATA} = '0;
		{CFG_ADDR, CFG_CTRL_EN, CFG_WD_TIMEOUT} = {6'h3F, 2'h1, 14'h0064};
		{CFG_ERR_ACT, CFG_IDLE_ACT, CFG_OUT_INST, CFG_IN_INST} = {3'h1, 3'h1, 8'h64, 8'h65};
		repeat (8) @(posedge CLK_SYS);
		RST_N <= 1'h1;
		t_reset;
		t_cfg;
		t_poll;
		t_ctrl;
		t_idle;
		t_wd;
		complete_run;
	end
endmodule
